// [rtl/ctd_pkg.sv]
package ctd_pkg;
  timeunit 1ns;
  timeprecision 1ps;

  // Opcodes of the test instruction family
  localparam logic [7:0] OP_PREFIX = 8'h9e;
  localparam logic [7:0] OP_TEST_DIRECT = 8'h3d;
  localparam logic [7:0] OP_TEST_ACCUM = 8'h4d;
  localparam logic [7:0] OP_TEST_INDEX_LOW = 8'h5d;
  localparam logic [7:0] OP_TEST_OFFSET8 = 8'h6d;
  localparam logic [7:0] OP_TEST_INDEXED = 8'h7d;
  localparam logic [7:0] OP_TEST_STACK_OFFSET8 = 8'h6d;
  // Transfer opcodes
  localparam logic [7:0] OP_STACK_TO_INDEX = 8'h95;
  localparam logic [7:0] OP_INDEX_TO_STACK = 8'h94;
  localparam logic [7:0] OP_INDEX_LOW_TO_ACCUM = 8'h9f;
  // Opcodes carrying the extra addressing modes
  localparam logic [7:0] OP_TEST_POSTINC = 8'h71;
  localparam logic [7:0] OP_TEST_OFFSET8_POSTINC = 8'h61;
  localparam logic [7:0] OP_MOVE_IMM_DIRECT = 8'h6e;
  localparam logic [7:0] OP_MOVE_POSTINC_DIRECT = 8'h7e;
  localparam logic [7:0] OP_TEST_OFFSET16 = 8'hdd;

  // Condition code bit positions and reset values
  localparam int CC_V_BIT = 7;
  localparam int CC_N_BIT = 2;
  localparam int CC_Z_BIT = 1;
  localparam logic [7:0] CC_RESET = 8'h68;
  localparam logic [15:0] SP_RESET = 16'h00ff;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [15:0] ONE_WORD = 16'h0001;

  typedef enum logic [3:0] {
    ST_BOOT, ST_OPC, ST_B1, ST_B2, ST_OPND, ST_DST, ST_WR, ST_XFER
  } ctd_state_e;

  typedef enum logic [3:0] {
    AM_DIR, AM_IX, AM_OFFSET8, AM_STACK_OFFSET8, AM_IX_POSTINC, AM_OFFSET8_POSTINC,
    AM_IMM_DIRECT, AM_IX_POSTINC_D, AM_OFFSET16
  } ctd_mode_e;

  // Memory request presented for one cycle
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } ctd_bus_s;

  // Programmer-visible core state
  typedef struct packed {
    logic [7:0] acc;
    logic [15:0] hx;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0] condition_code_reg;
  } ctd_regs_s;

endpackage

// [rtl/ctd_core.sv]
// Contract
// - Test sets N and Z from accumulator, index low or memory, clears V, keeps the rest.
// - Indexed no-offset post-increment form addresses by H:X and then increments H:X.
// - Indexed 8-bit offset post-increment form adds an unsigned byte to H:X then increments H:X.
// - Immediate-to-direct move writes an immediate byte to a direct-page address.
// - Indexed-to-direct move reads at H:X, increments H:X and writes to direct page.
// - Indexed 16-bit offset form adds a high:low offset to H:X for the address.
module ctd_core
  import ctd_pkg::*;
#(
  parameter logic [15:0] RESET_PC = PC_RESET
)(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Memory bus, read data answers the current request
  input wire logic [7:0] mem_rdata,
  output ctd_bus_s mem_req,
  // Core state
  output ctd_regs_s core_regs
);
  timeunit 1ns;
  timeprecision 1ps;

  ctd_state_e state_q;
  ctd_mode_e mode_q;
  logic prefix_q;
  logic [7:0] b1_q;
  logic [7:0] data_q;
  ctd_bus_s bus_q;
  ctd_regs_s r_q;

  // Address sum, wraps at 64K like the index arithmetic
  function automatic logic [15:0] addr_add(input logic [15:0] base, input logic [15:0] off);
    logic [16:0] s;
    s = {1'b0, base} + {1'b0, off};
    return s[15:0];
  endfunction

  // Direct page address from one byte
  function automatic logic [15:0] dpage(input logic [7:0] a);
    return {ZERO_BYTE, a};
  endfunction

  // Present a read for the next cycle
  task automatic issue_read(input logic [15:0] a);
    bus_q.rd <= 1'b1;
    bus_q.wr <= 1'b0;
    bus_q.addr <= a;
    bus_q.wdata <= ZERO_BYTE;
  endtask

  // Flags from a tested byte; other bits are untouched
  task automatic set_nz(input logic [7:0] v);
    r_q.condition_code_reg[CC_N_BIT] <= v[7];
    r_q.condition_code_reg[CC_Z_BIT] <= (v == ZERO_BYTE);
    r_q.condition_code_reg[CC_V_BIT] <= 1'b0;
  endtask

  // Opcode fetch; ends every instruction
  task automatic fetch_next();
    issue_read(r_q.pc);
    r_q.pc <= addr_add(r_q.pc, ONE_WORD);
    prefix_q <= 1'b0;
    state_q <= ST_OPC;
  endtask

  // Sequencer, bus and register update share one process since
  // every state but ST_BOOT, ST_WR and ST_XFER consumes read data and, but for ST_OPC on a transfer opcode, schedules the next access
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_q <= ST_BOOT;
      mode_q <= AM_DIR;
      prefix_q <= 1'b0;
      b1_q <= ZERO_BYTE;
      data_q <= ZERO_BYTE;
      bus_q <= '0;
      r_q.acc <= ZERO_BYTE;
      r_q.hx <= '0;
      r_q.sp <= SP_RESET;
      r_q.pc <= RESET_PC;
      r_q.condition_code_reg <= CC_RESET;
    end
    else
    begin
      // Default: bus idle unless a state issues an access
      bus_q <= '0;
      case (state_q)
        ST_BOOT:
        begin
          fetch_next();
        end
        ST_OPC:
        begin
          if (!prefix_q && mem_rdata == OP_PREFIX)
          begin
            // Prefix costs one cycle, then the second opcode
            issue_read(r_q.pc);
            r_q.pc <= addr_add(r_q.pc, ONE_WORD);
            prefix_q <= 1'b1;
          end
          else if (prefix_q)
          begin
            if (mem_rdata == OP_TEST_STACK_OFFSET8)
            begin
              mode_q <= AM_STACK_OFFSET8;
              issue_read(r_q.pc);
              r_q.pc <= addr_add(r_q.pc, ONE_WORD);
              state_q <= ST_B1;
            end
            else
            begin
              // Unknown prefixed opcode runs as a no-op
              fetch_next();
            end
          end
          else
          begin
            case (mem_rdata)
              OP_TEST_ACCUM:
              begin
                set_nz(r_q.acc);
                fetch_next();
              end
              OP_TEST_INDEX_LOW:
              begin
                set_nz(r_q.hx[7:0]);
                fetch_next();
              end
              OP_INDEX_LOW_TO_ACCUM:
              begin
                r_q.acc <= r_q.hx[7:0];
                fetch_next();
              end
              OP_STACK_TO_INDEX:
              begin
                r_q.hx <= addr_add(r_q.sp, ONE_WORD);
                state_q <= ST_XFER;
              end
              OP_INDEX_TO_STACK:
              begin
                r_q.sp <= r_q.hx - ONE_WORD;
                state_q <= ST_XFER;
              end
              OP_TEST_INDEXED:
              begin
                mode_q <= AM_IX;
                issue_read(r_q.hx);
                state_q <= ST_OPND;
              end
              OP_TEST_POSTINC:
              begin
                mode_q <= AM_IX_POSTINC;
                issue_read(r_q.hx);
                state_q <= ST_OPND;
              end
              OP_MOVE_POSTINC_DIRECT:
              begin
                mode_q <= AM_IX_POSTINC_D;
                issue_read(r_q.hx);
                state_q <= ST_OPND;
              end
              OP_TEST_DIRECT, OP_TEST_OFFSET8, OP_TEST_OFFSET8_POSTINC,
              OP_MOVE_IMM_DIRECT, OP_TEST_OFFSET16:
              begin
                case (mem_rdata)
                  OP_TEST_DIRECT: mode_q <= AM_DIR;
                  OP_TEST_OFFSET8: mode_q <= AM_OFFSET8;
                  OP_TEST_OFFSET8_POSTINC: mode_q <= AM_OFFSET8_POSTINC;
                  OP_MOVE_IMM_DIRECT: mode_q <= AM_IMM_DIRECT;
                  default: mode_q <= AM_OFFSET16;
                endcase
                issue_read(r_q.pc);
                r_q.pc <= addr_add(r_q.pc, ONE_WORD);
                state_q <= ST_B1;
              end
              default:
              begin
                fetch_next();
              end
            endcase
          end
        end
        ST_B1:
        begin
          b1_q <= mem_rdata;
          state_q <= ST_OPND;
          case (mode_q)
            AM_DIR: issue_read(dpage(mem_rdata));
            AM_STACK_OFFSET8: issue_read(addr_add(r_q.sp, dpage(mem_rdata)));
            AM_OFFSET8, AM_OFFSET8_POSTINC:
              issue_read(addr_add(r_q.hx, dpage(mem_rdata)));
            AM_IMM_DIRECT:
            begin
              // Immediate source held until the destination arrives
              data_q <= mem_rdata;
              issue_read(r_q.pc);
              r_q.pc <= addr_add(r_q.pc, ONE_WORD);
              state_q <= ST_DST;
            end
            default:
            begin
              // High offset byte; low byte follows
              issue_read(r_q.pc);
              r_q.pc <= addr_add(r_q.pc, ONE_WORD);
              state_q <= ST_B2;
            end
          endcase
        end
        ST_B2:
        begin
          issue_read(addr_add(r_q.hx, {b1_q, mem_rdata}));
          state_q <= ST_OPND;
        end
        ST_OPND:
        begin
          if (mode_q == AM_IX_POSTINC || mode_q == AM_OFFSET8_POSTINC
              || mode_q == AM_IX_POSTINC_D)
          begin
            // Increment only after the access has used the old index
            r_q.hx <= addr_add(r_q.hx, ONE_WORD);
          end
          if (mode_q == AM_IX_POSTINC_D)
          begin
            data_q <= mem_rdata;
            issue_read(r_q.pc);
            r_q.pc <= addr_add(r_q.pc, ONE_WORD);
            state_q <= ST_DST;
          end
          else
          begin
            set_nz(mem_rdata);
            fetch_next();
          end
        end
        ST_DST:
        begin
          // Moves flag the byte moved, as tests do
          set_nz(data_q);
          bus_q.rd <= 1'b0;
          bus_q.wr <= 1'b1;
          bus_q.addr <= dpage(mem_rdata);
          bus_q.wdata <= data_q;
          state_q <= ST_WR;
        end
        ST_WR, ST_XFER:
        begin
          // Second cycle of a transfer, or write completing
          fetch_next();
        end
        default:
        begin
          fetch_next();
        end
      endcase
    end
  end

  // Outputs straight from flops
  assign mem_req = bus_q;
  assign core_regs = r_q;

endmodule // ctd_core

// [verif/ctd_core_assertions.sv]
module ctd_core_checker
  import ctd_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Bus and state
  input wire logic [7:0] mem_rdata,
  input wire ctd_bus_s mem_req,
  input wire ctd_regs_s core_regs
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Transfer: one idle bus cycle, then the next fetch
  sequence idle_then_fetch;
    !mem_req.rd && !mem_req.wr ##1 mem_req.rd;
  endsequence

  chk_sp_from_index: assert property ($changed(core_regs.sp) |->
    (core_regs.sp == $past(core_regs.hx) - 16'h0001) ##0 idle_then_fetch)
    else $error("stack pointer load wrong");
  chk_index_load_timing: assert property ($changed(core_regs.hx) &&
    core_regs.hx == $past(core_regs.sp) + 16'h0001 &&
    core_regs.hx != $past(core_regs.hx) + 16'h0001 |-> idle_then_fetch)
    else $error("index load timing wrong");
  chk_hx_source: assert property ($changed(core_regs.hx) |->
    core_regs.hx == $past(core_regs.hx) + 16'h0001 ||
    core_regs.hx == $past(core_regs.sp) + 16'h0001)
    else $error("index changed by wrong amount");
  chk_acc_source: assert property ($changed(core_regs.acc) |->
    core_regs.acc == $past(core_regs.hx[7:0]))
    else $error("accumulator from wrong source");
  chk_flags_kept: assert property ($changed(core_regs.condition_code_reg) |->
    !core_regs.condition_code_reg[7] &&
    (core_regs.condition_code_reg & 8'h79) == ($past(core_regs.condition_code_reg) & 8'h79))
    else $error("flag update touched other bits");
  chk_move_flags: assert property (mem_req.wr |->
    core_regs.condition_code_reg[2] == mem_req.wdata[7] &&
    core_regs.condition_code_reg[1] == (mem_req.wdata == 8'h00)
    && mem_req.addr[15:8] == 8'h00)
    else $error("move flags or page wrong");
  chk_write_then_fetch: assert property (mem_req.wr |-> !mem_req.rd ##1 mem_req.rd)
    else $error("no fetch after write");
endmodule // ctd_core_checker

bind ctd_core ctd_core_checker u_chk (.ref_clk(ref_clk), .rst(rst), .mem_rdata(mem_rdata),
  .mem_req(mem_req), .core_regs(core_regs));

// [verif/ctd_mem_model.sv]
module ctd_mem_model
  import ctd_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Bus
  input wire ctd_bus_s mem_req,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h00;

  // Idle bus shows inverted last byte, never a stale copy
  always_comb mem_rdata = mem_req.rd ? mem[mem_req.addr] : ~last_q;

  // Writes commit at the edge ending the cycle
  always @(posedge ref_clk)
  begin
    if (mem_req.rd) last_q <= mem_rdata;
    if (mem_req.wr) mem[mem_req.addr] <= mem_req.wdata;
  end
endmodule // ctd_mem_model

// [verif/cpu_test_transfer_decode_tb.sv]
module cpu_test_transfer_decode_tb;
  import ctd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] mem_rdata;
  ctd_bus_s mem_req;
  ctd_regs_s core_regs;
  int bad_count = 0;
  int total_checks = 0;
  int seed = 40482;
  logic [15:0] seen [$];
  localparam logic [7:0] PROG [0:24] = '{8'h95, 8'h71, 8'h61, 8'h02, 8'hdd, 8'h01, 8'h00,
    8'h6e, 8'h00, 8'h80, 8'h7e, 8'h81, 8'h94, 8'h9e, 8'h6d, 8'h01, 8'h9f, 8'h4d, 8'h5d,
    8'h3d, 8'h82, 8'h6d, 8'h05, 8'h7d, 8'h9d};
  localparam logic [15:0] RD [0:7] = '{16'h0100, 16'h0103, 16'h0202, 16'h0102, 16'h0103,
    16'h0082, 16'h0108, 16'h0103};

  always #20 ref_clk = ~ref_clk;

  ctd_core dut (.ref_clk(ref_clk), .rst(rst), .mem_rdata(mem_rdata), .mem_req(mem_req),
    .core_regs(core_regs));
  ctd_mem_model mem_model (.ref_clk(ref_clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

  // Operand addresses outside the program area
  always @(posedge ref_clk)
    if (!rst && mem_req.rd && (mem_req.addr[15:8] != 8'h00 || mem_req.addr[7]))
      seen.push_back(mem_req.addr);

  function automatic logic [7:0] pick(input int it);
    if (it == 0) return 8'h00;
    if (it == 1) return 8'h80;
    return 8'($random(seed));
  endfunction

  // Flags after a test of the byte at an address; V stays clear from reset
  function automatic logic [7:0] exp_flags(input logic [15:0] a);
    return CC_RESET | {5'h00, mem_model.mem[a][7], mem_model.mem[a] == 8'h00, 1'b0};
  endfunction

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog, far beyond six short programs
  initial
  begin
    #80000;
    bad_count++;
    summarize();
  end

  // Random data, first two runs pin zero and negative bytes
  initial
  begin
    int n;
    for (int it = 0; it < 6; it++)
    begin
      // First run starts in reset; later runs reset in mid-run
      if (it > 0)
      begin
        @(posedge ref_clk);
        #1 rst = 1'b1;
      end
      for (int a = 0; a < 16'h0210; a++)
        mem_model.mem[a] = a < 16'h0080 ? 8'h9d : pick(it);
      for (int a = 0; a < 25; a++)
        mem_model.mem[a] = PROG[a];
      mem_model.mem[8] = pick(it);
      seen.delete();
      repeat (3) @(posedge ref_clk);
      #1 rst = 1'b0;
      n = 0;
      while (!(mem_req.rd === 1'b1 && mem_req.addr === 16'h0018) && n < 200)
      begin
        @(posedge ref_clk);
        #1 n++;
      end
      check("end fetch", 16'h0018, mem_req.addr);
      check("flags", exp_flags(16'h0103), core_regs.condition_code_reg);
      check("hx", 16'h0103, core_regs.hx);
      check("sp", 16'h0102, core_regs.sp);
      check("acc", 16'h0003, core_regs.acc);
      check("imm move", mem_model.mem[8], mem_model.mem[16'h0080]);
      check("index move", mem_model.mem[16'h0102], mem_model.mem[16'h0081]);
      check("reads", 16'd8, 16'(seen.size()));
      for (int k = 0; k < 8 && k < seen.size(); k++)
        check("read addr", RD[k], seen[k]);
    end
    summarize();
  end
endmodule // cpu_test_transfer_decode_tb
